// >>> alarm_irq_pkg.sv
// Purpose: constants for the alarm polarity and interrupt mask block
// Assumes: byte-wide registers at the printed offsets
// Notes:   reset values and writable-bit masks live here
package alarm_irq_pkg;

  // ---------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] POL_CFG_OFFSET   = 8'h16;
  localparam logic [7:0] LOSS_MASK_OFFSET = 8'h17;
  localparam logic [7:0] FLA_MASK_OFFSET  = 8'h18;

  // ---------------------------------------------------------------------
  // reset values and writable bits
  // ---------------------------------------------------------------------
  localparam logic [7:0] POL_CFG_RESET    = 8'hDF;
  localparam logic [7:0] LOSS_MASK_RESET  = 8'h1F;
  localparam logic [7:0] FLA_MASK_RESET   = 8'h3F;
  localparam logic [7:0] POL_CFG_WMASK    = 8'hDF;
  localparam logic [7:0] LOSS_MASK_WMASK  = 8'h1F;
  localparam logic [7:0] FLA_MASK_WMASK   = 8'h3F;

  // ---------------------------------------------------------------------
  // polarity register fields
  // ---------------------------------------------------------------------
  localparam int FRAME_REALIGN_INPUT_POLARITY_BIT    = 7;
  localparam int FRAME_SYNC_INPUT_POLARITY_BIT       = 6;
  localparam int FRAME_SYNC_OUTPUT_POLARITY_BIT      = 4;
  localparam int ACTIVE_CLOCK_INDICATOR_POLARITY_BIT = 3;
  localparam int BAD_CLOCK_INDICATOR_POLARITY_BIT    = 2;
  localparam int LOCK_LOSS_PIN_POLARITY_BIT          = 1;
  localparam int IRQ_PIN_POLARITY_BIT                = 0;

  // ---------------------------------------------------------------------
  // output pin slots
  // ---------------------------------------------------------------------
  localparam int PIN_COUNT     = 10;
  localparam int PIN_ACTV_BASE = 0;
  localparam int PIN_BAD_BASE  = 4;
  localparam int PIN_LOL       = 7;
  localparam int PIN_FSYNC_OUT = 8;
  localparam int PIN_IRQ       = 9;

  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

// >>> pin_drive.sv
// Purpose: one output pin with selectable active level and enable
// Assumes: level_i is active high internally
// Notes:   pin and enable come straight from flops
`timescale 1ns/1ps
module pin_drive (
  input  wire logic clk_i,      // system clock
  input  wire logic rst_n_i,    // async reset, active low
  input  wire logic level_i,    // internal status, active high
  input  wire logic pol_i,      // 1 active high, 0 active low
  input  wire logic en_i,       // reflect on pin
  output logic      pin_o,      // pin level
  output logic      oe_o        // pin driven when high
);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      oe_o  <= 1'b0;
    end else begin
      pin_o <= pol_i ? level_i : ~level_i;
      oe_o  <= en_i;
    end
  end

endmodule

// >>> alarm_polarity_and_irq_mask.sv
// Purpose: pin polarity configuration and alarm interrupt masking
// Assumes: register port is the internal side of the serial port
// Notes:   alarm flags are held outside and are only read here
`timescale 1ns/1ps
module alarm_polarity_and_irq_mask (
  input  wire logic       CLK_I,          // 50 MHz system clock
  input  wire logic       RST_N_I,        // async reset, active low
  input  wire logic [7:0] REG_ADDR_I,     // register offset
  input  wire logic       REG_WR_I,       // write strobe
  input  wire logic [7:0] REG_WDATA_I,    // write data
  input  wire logic       REG_RD_I,       // read strobe
  output logic      [7:0] REG_RDATA_O,    // read data, next cycle
  input  wire logic [3:0] LOSS_FLAG_I,    // input4..1 signal loss flags
  input  wire logic       XTAL_LOSS_I,    // crystal signal loss flag
  input  wire logic       ALIGN_FLAG_I,   // frame alignment alarm flag
  input  wire logic [3:0] FOS_FLAG_I,     // input4..1 freq offset flags
  input  wire logic       LOL_FLAG_I,     // lock loss flag
  input  wire logic       IRQ_REFL_EN_I,  // reflect irq on shared pin
  input  wire logic       ALRM_REFL_EN_I, // summary alarm reflect enable
  input  wire logic       ALRM_STAT_I,    // summary alarm status
  input  wire logic [3:0] ACTV_STAT_I,    // active clock status 4..1
  input  wire logic [3:0] ACTV_EN_I,      // active pin enables 4..1
  input  wire logic [2:0] BAD_STAT_I,     // bad clock status 3..1
  input  wire logic [2:0] BAD_EN_I,       // bad pin enables 3..1
  input  wire logic       LOL_STAT_I,     // lock loss status
  input  wire logic       LOL_EN_I,       // lock loss pin enable
  input  wire logic       FSYNC_STAT_I,   // frame sync output, active high
  input  wire logic       REALIGN_PIN_I,  // frame realign input pin
  input  wire logic [1:0] FSYNC_PIN_I,    // clock input four/three pins
  output logic            IRQ_STATUS_O,   // interrupt status, active high
  output logic            REALIGN_O,      // realign active edge pulse
  output logic            REALIGN_LVL_O,  // realign pin asserted level
  output logic      [1:0] FSYNC_EDGE_O,   // frame sync edge pulses 4/3
  output logic      [3:0] ACTV_PIN_O,     // active indicator pins 4..1
  output logic      [3:0] ACTV_OE_O,      // active indicator enables
  output logic      [2:0] BAD_PIN_O,      // bad indicator pins 3..1
  output logic      [2:0] BAD_OE_O,       // bad indicator enables
  output logic            LOL_PIN_O,      // lock loss pin
  output logic            LOL_OE_O,       // lock loss pin enable
  output logic            FSYNC_OUT_O,    // frame sync output pin
  output logic            FSYNC_OUT_OE_O, // frame sync output enable
  output logic            IRQ_PIN_O,      // shared irq/alarm pin
  output logic            IRQ_OE_O        // shared pin enable
);

  // ---------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------
  logic [7:0] pin_polarity_config_r;
  logic [7:0] signal_loss_irq_mask_r;
  logic [7:0] freq_lock_align_irq_mask_r;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_polarity_config_r <= alarm_irq_pkg::POL_CFG_RESET;
    end else if (REG_WR_I &&
                 REG_ADDR_I == alarm_irq_pkg::POL_CFG_OFFSET) begin
      // reserved bit 5 stays zero
      pin_polarity_config_r <= REG_WDATA_I &
                               alarm_irq_pkg::POL_CFG_WMASK;
    end
  end

  // mask writes touch only these flops, never the flags
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      signal_loss_irq_mask_r <= alarm_irq_pkg::LOSS_MASK_RESET;
    end else if (REG_WR_I &&
                 REG_ADDR_I == alarm_irq_pkg::LOSS_MASK_OFFSET) begin
      signal_loss_irq_mask_r <= REG_WDATA_I & alarm_irq_pkg::LOSS_MASK_WMASK;
    end
  end

  // bits 7:6 are reserved and never stored
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      freq_lock_align_irq_mask_r <=
        alarm_irq_pkg::FLA_MASK_RESET;
    end else if (REG_WR_I &&
                 REG_ADDR_I == alarm_irq_pkg::FLA_MASK_OFFSET) begin
      freq_lock_align_irq_mask_r <= REG_WDATA_I &
                                    alarm_irq_pkg::FLA_MASK_WMASK;
    end
  end

  // ---------------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------------
  logic [7:0] rdata_nxt;

  always_comb begin
    unique case (REG_ADDR_I)
      alarm_irq_pkg::POL_CFG_OFFSET:   rdata_nxt = pin_polarity_config_r;
      alarm_irq_pkg::LOSS_MASK_OFFSET: rdata_nxt = signal_loss_irq_mask_r;
      alarm_irq_pkg::FLA_MASK_OFFSET:  rdata_nxt = freq_lock_align_irq_mask_r;
      default:
        rdata_nxt = alarm_irq_pkg::READ_UNMAPPED;
    endcase
  end

  // read data holds between reads
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= alarm_irq_pkg::READ_UNMAPPED;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // field aliases
  // ---------------------------------------------------------------------
  logic       frame_realign_input_polarity;
  logic       frame_sync_input_polarity;
  logic       frame_sync_output_polarity;
  logic       active_clock_indicator_polarity;
  logic       bad_clock_indicator_polarity;
  logic       lock_loss_pin_polarity;
  logic       irq_pin_polarity;
  logic [3:0] signal_loss_mask;
  logic       crystal_signal_loss_mask;
  logic       frame_alignment_alarm_mask;
  logic [3:0] freq_offset_mask;
  logic       lock_loss_irq_mask;

  assign frame_realign_input_polarity = pin_polarity_config_r[
    alarm_irq_pkg::FRAME_REALIGN_INPUT_POLARITY_BIT];
  assign frame_sync_input_polarity = pin_polarity_config_r[
    alarm_irq_pkg::FRAME_SYNC_INPUT_POLARITY_BIT];
  assign frame_sync_output_polarity = pin_polarity_config_r[
    alarm_irq_pkg::FRAME_SYNC_OUTPUT_POLARITY_BIT];
  assign active_clock_indicator_polarity = pin_polarity_config_r[
    alarm_irq_pkg::ACTIVE_CLOCK_INDICATOR_POLARITY_BIT];
  assign bad_clock_indicator_polarity = pin_polarity_config_r[
    alarm_irq_pkg::BAD_CLOCK_INDICATOR_POLARITY_BIT];
  assign lock_loss_pin_polarity = pin_polarity_config_r[
    alarm_irq_pkg::LOCK_LOSS_PIN_POLARITY_BIT];
  assign irq_pin_polarity = pin_polarity_config_r[
    alarm_irq_pkg::IRQ_PIN_POLARITY_BIT];

  assign signal_loss_mask           = signal_loss_irq_mask_r[4:1];
  assign crystal_signal_loss_mask   = signal_loss_irq_mask_r[0];
  assign frame_alignment_alarm_mask = freq_lock_align_irq_mask_r[5];
  assign freq_offset_mask           = freq_lock_align_irq_mask_r[4:1];
  assign lock_loss_irq_mask         = freq_lock_align_irq_mask_r[0];

  // ---------------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------------
  logic [3:0] loss_term;
  logic       xtal_term;
  logic       align_term;
  logic [3:0] fos_term;
  logic       lol_term;
  logic       irq_nxt;

  // one term per alarm source; a set mask bit drops that source only
  always_comb begin
    loss_term  = LOSS_FLAG_I & ~signal_loss_mask;
    xtal_term  = XTAL_LOSS_I & ~crystal_signal_loss_mask;
    align_term = ALIGN_FLAG_I & ~frame_alignment_alarm_mask;
    fos_term[3:1] = FOS_FLAG_I[3:1] & ~freq_offset_mask[3:1];
    fos_term[0]   = FOS_FLAG_I[0] & ~freq_offset_mask[0];
    lol_term   = LOL_FLAG_I & ~lock_loss_irq_mask;
    irq_nxt    = (|loss_term) | xtal_term | align_term
               | (|fos_term) | lol_term;
  end

  // status stays true-polarity; pin applies the level
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_STATUS_O <= 1'b0;
    end else begin
      IRQ_STATUS_O <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // input pin edge recognition
  // ---------------------------------------------------------------------
  logic       realign_prev_r;
  logic [1:0] fsync_prev_r;

  // prev starts at 0, the idle level of both pins at reset polarity
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      realign_prev_r <= 1'b0;
      fsync_prev_r   <= 2'h0;
    end else begin
      realign_prev_r <= REALIGN_PIN_I;
      fsync_prev_r   <= FSYNC_PIN_I;
    end
  end

  // 1 detects rising edge, 0 falling edge
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REALIGN_O     <= 1'b0;
      REALIGN_LVL_O <= 1'b0;
    end else begin
      REALIGN_O <= frame_realign_input_polarity ?
                   (REALIGN_PIN_I & ~realign_prev_r) :
                   (~REALIGN_PIN_I & realign_prev_r);
      REALIGN_LVL_O <= ~(REALIGN_PIN_I ^
                         frame_realign_input_polarity);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FSYNC_EDGE_O <= 2'h0;
    end else begin
      FSYNC_EDGE_O <= frame_sync_input_polarity ?
                      (FSYNC_PIN_I & ~fsync_prev_r) :
                      (~FSYNC_PIN_I & fsync_prev_r);
    end
  end

  // ---------------------------------------------------------------------
  // output pins
  // ---------------------------------------------------------------------
  logic [alarm_irq_pkg::PIN_COUNT-1:0] pin_level;
  logic [alarm_irq_pkg::PIN_COUNT-1:0] pin_pol;
  logic [alarm_irq_pkg::PIN_COUNT-1:0] pin_en;
  logic [alarm_irq_pkg::PIN_COUNT-1:0] pin_val;
  logic [alarm_irq_pkg::PIN_COUNT-1:0] pin_oe;
  logic                                shared_level;
  logic                                shared_pol;

  // ---------------------------------------------------------------------
  // shared irq/alarm pin source
  // ---------------------------------------------------------------------
  // irq reflection overrides the summary alarm request
  always_comb begin
    if (IRQ_REFL_EN_I) begin
      shared_level = irq_nxt;
      shared_pol   = irq_pin_polarity;
    end else begin
      shared_level = ALRM_STAT_I;
      shared_pol   = bad_clock_indicator_polarity;
    end
  end

  // slots follow the package indices, so a moved slot cannot skew pins
  always_comb begin
    pin_level = '0;
    pin_pol   = '0;
    pin_en    = '0;

    pin_level[alarm_irq_pkg::PIN_ACTV_BASE +: 4] = ACTV_STAT_I;
    pin_pol[alarm_irq_pkg::PIN_ACTV_BASE +: 4]   =
      {4{active_clock_indicator_polarity}};
    pin_en[alarm_irq_pkg::PIN_ACTV_BASE +: 4]    = ACTV_EN_I;

    pin_level[alarm_irq_pkg::PIN_BAD_BASE +: 3] = BAD_STAT_I;
    pin_pol[alarm_irq_pkg::PIN_BAD_BASE +: 3]   =
      {3{bad_clock_indicator_polarity}};
    pin_en[alarm_irq_pkg::PIN_BAD_BASE +: 3]    = BAD_EN_I;

    pin_level[alarm_irq_pkg::PIN_LOL] = LOL_STAT_I;
    pin_pol[alarm_irq_pkg::PIN_LOL]   =
      lock_loss_pin_polarity;
    pin_en[alarm_irq_pkg::PIN_LOL]    = LOL_EN_I;

    // frame sync output is always driven
    pin_level[alarm_irq_pkg::PIN_FSYNC_OUT] = FSYNC_STAT_I;
    pin_pol[alarm_irq_pkg::PIN_FSYNC_OUT]   =
      frame_sync_output_polarity;
    pin_en[alarm_irq_pkg::PIN_FSYNC_OUT]    = 1'b1;

    pin_level[alarm_irq_pkg::PIN_IRQ] = shared_level;
    pin_pol[alarm_irq_pkg::PIN_IRQ]   = shared_pol;
    pin_en[alarm_irq_pkg::PIN_IRQ]    =
      IRQ_REFL_EN_I | ALRM_REFL_EN_I;
  end

  // every pin value and enable leaves through a flop
  genvar gi;
  generate
    for (gi = 0; gi < alarm_irq_pkg::PIN_COUNT; gi++) begin : g_pin
      pin_drive u_pin (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .level_i (pin_level[gi]),
        .pol_i   (pin_pol[gi]),
        .en_i    (pin_en[gi]),
        .pin_o   (pin_val[gi]),
        .oe_o    (pin_oe[gi])
      );
    end
  endgenerate

  // unpack the flopped slots onto the named pins
  assign ACTV_PIN_O     = pin_val[alarm_irq_pkg::PIN_ACTV_BASE +: 4];
  assign ACTV_OE_O      = pin_oe[alarm_irq_pkg::PIN_ACTV_BASE +: 4];
  assign BAD_PIN_O      = pin_val[alarm_irq_pkg::PIN_BAD_BASE +: 3];
  assign BAD_OE_O       = pin_oe[alarm_irq_pkg::PIN_BAD_BASE +: 3];
  assign LOL_PIN_O      = pin_val[alarm_irq_pkg::PIN_LOL];
  assign LOL_OE_O       = pin_oe[alarm_irq_pkg::PIN_LOL];
  assign FSYNC_OUT_O    = pin_val[alarm_irq_pkg::PIN_FSYNC_OUT];
  assign FSYNC_OUT_OE_O = pin_oe[alarm_irq_pkg::PIN_FSYNC_OUT];
  assign IRQ_PIN_O      = pin_val[alarm_irq_pkg::PIN_IRQ];
  assign IRQ_OE_O       = pin_oe[alarm_irq_pkg::PIN_IRQ];

endmodule

// >>> host_pin_watch.sv
// Purpose: board side of the shared irq/alarm pin
// Assumes: the board holds the line with a pull-up
// Notes:   a released pin reads high, never the last driven value
`timescale 1ns/1ps
module host_pin_watch (
  input  wire logic pin_i,  // device pin value
  input  wire logic oe_i,   // device drives the pin
  output logic      wire_o  // level seen by board logic
);
  assign wire_o = oe_i ? pin_i : 1'b1;
endmodule

// >>> alarm_irq_monitor.sv
// Purpose: concurrent checks on polarity, masking and pin reflection
// Assumes: shadow registers update on the same edge as the block's
// Notes:   bound to the block at the foot of this file
`timescale 1ns/1ps
module alarm_irq_monitor (
  input logic       CLK_I,          // clock
  input logic       RST_N_I,        // async reset, active low
  input logic [7:0] REG_ADDR_I,     // register offset
  input logic       REG_WR_I,       // write strobe
  input logic [7:0] REG_WDATA_I,    // write data
  input logic       REG_RD_I,       // read strobe
  input logic [7:0] REG_RDATA_O,    // read data
  input logic [3:0] LOSS_FLAG_I,    // loss flags
  input logic       XTAL_LOSS_I,    // crystal loss flag
  input logic       ALIGN_FLAG_I,   // alignment alarm flag
  input logic [3:0] FOS_FLAG_I,     // offset flags
  input logic       LOL_FLAG_I,     // lock loss flag
  input logic       IRQ_REFL_EN_I,  // irq reflect enable
  input logic       ALRM_REFL_EN_I, // alarm reflect enable
  input logic       ALRM_STAT_I,    // summary alarm status
  input logic       LOL_STAT_I,     // lock loss status
  input logic       LOL_EN_I,       // lock loss pin enable
  input logic       FSYNC_STAT_I,   // frame sync status
  input logic       REALIGN_PIN_I,  // realign pin
  input logic       IRQ_STATUS_O,   // irq status
  input logic       REALIGN_O,      // realign pulse
  input logic       LOL_PIN_O,      // lock loss pin
  input logic       LOL_OE_O,       // lock loss enable
  input logic       FSYNC_OUT_O,    // frame sync pin
  input logic       FSYNC_OUT_OE_O, // frame sync enable
  input logic       IRQ_PIN_O,      // shared pin
  input logic       IRQ_OE_O        // shared pin enable
);
  // ---------------------------------------------------------------------
  // register shadows
  // ---------------------------------------------------------------------
  logic [7:0] pol_r;
  logic [7:0] lm_r;
  logic [7:0] fm_r;
  logic [7:0] rd_exp;
  logic       up_r;
  logic       rl_prev_r;
  logic       irq_exp;
  logic       rl_edge;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pol_r <= alarm_irq_pkg::POL_CFG_RESET;
      lm_r  <= alarm_irq_pkg::LOSS_MASK_RESET;
      fm_r  <= alarm_irq_pkg::FLA_MASK_RESET;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == 8'h16) pol_r <= REG_WDATA_I & 8'hDF;
      if (REG_ADDR_I == 8'h17) lm_r <= REG_WDATA_I & 8'h1F;
      if (REG_ADDR_I == 8'h18) fm_r <= REG_WDATA_I & 8'h3F;
    end
  end

  // up_r hides the first edge after release from $past
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      up_r      <= 1'b0;
      rl_prev_r <= 1'b0;
    end else begin
      up_r      <= 1'b1;
      rl_prev_r <= REALIGN_PIN_I;
    end
  end

  always_comb begin
    case (REG_ADDR_I)
      8'h16:   rd_exp = pol_r;
      8'h17:   rd_exp = lm_r;
      8'h18:   rd_exp = fm_r;
      default: rd_exp = 8'h00;
    endcase
  end

  assign irq_exp = |({LOSS_FLAG_I, XTAL_LOSS_I} & ~lm_r[4:0])
                 | |({ALIGN_FLAG_I, FOS_FLAG_I, LOL_FLAG_I} & ~fm_r[5:0]);
  assign rl_edge = (REALIGN_PIN_I != rl_prev_r) && (REALIGN_PIN_I == pol_r[7]);

  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_rl_edge;
    rl_edge;
  endsequence
  sequence s_rl_pulse;
    REALIGN_O ##1 !REALIGN_O;
  endsequence

  a_irq_or_unmasked: assert property (
    up_r |-> IRQ_STATUS_O == $past(irq_exp))
    else $error("irq status differs from unmasked flags");
  a_irq_pin_level: assert property (
    up_r && $past(IRQ_REFL_EN_I) |-> IRQ_OE_O
      && (IRQ_PIN_O == (IRQ_STATUS_O ~^ $past(pol_r[0]))))
    else $error("shared pin does not show irq level");
  a_alarm_pin_level: assert property (
    up_r && !$past(IRQ_REFL_EN_I) && $past(ALRM_REFL_EN_I) |-> IRQ_OE_O
      && (IRQ_PIN_O == ($past(ALRM_STAT_I) ~^ $past(pol_r[2]))))
    else $error("shared pin does not show alarm level");
  a_shared_pin_off: assert property (
    up_r && !$past(IRQ_REFL_EN_I) && !$past(ALRM_REFL_EN_I) |-> !IRQ_OE_O)
    else $error("shared pin driven with both reflects off");
  a_lol_pin_level: assert property (
    up_r && $past(LOL_EN_I) |-> LOL_OE_O
      && (LOL_PIN_O == ($past(LOL_STAT_I) ~^ $past(pol_r[1]))))
    else $error("lock loss pin level wrong");
  a_fsync_out_level: assert property (
    up_r |-> FSYNC_OUT_OE_O
      && (FSYNC_OUT_O == ($past(FSYNC_STAT_I) ~^ $past(pol_r[4]))))
    else $error("frame sync output level wrong");
  a_realign_edge: assert property (
    s_rl_edge |=> s_rl_pulse)
    else $error("realign edge not a single pulse");
  a_reg_read_back: assert property (
    REG_RD_I |=> REG_RDATA_O == $past(rd_exp))
    else $error("register read value wrong");
endmodule

bind alarm_polarity_and_irq_mask alarm_irq_monitor u_alarm_irq_monitor (.*);

// >>> alarm_polarity_and_irq_mask_tb_top.sv
// Purpose: directed tests of registers, masking, pin levels and edges
// Assumes: inputs change at the falling edge
// Notes:   the shared pin is resolved through the board model
`timescale 1ns/1ps
module alarm_polarity_and_irq_mask_tb_top;
  logic       CLK_I, RST_N_I, REG_WR_I, REG_RD_I, XTAL_LOSS_I, ALIGN_FLAG_I;
  logic       LOL_FLAG_I, IRQ_REFL_EN_I, ALRM_REFL_EN_I, ALRM_STAT_I;
  logic       LOL_STAT_I, LOL_EN_I, FSYNC_STAT_I, REALIGN_PIN_I, IRQ_STATUS_O;
  logic       REALIGN_O, REALIGN_LVL_O, LOL_PIN_O, LOL_OE_O, FSYNC_OUT_O;
  logic       FSYNC_OUT_OE_O, IRQ_PIN_O, IRQ_OE_O, irq_wire, p;
  logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O;
  logic [3:0] LOSS_FLAG_I, FOS_FLAG_I, ACTV_STAT_I, ACTV_EN_I;
  logic [3:0] ACTV_PIN_O, ACTV_OE_O;
  logic [2:0] BAD_STAT_I, BAD_EN_I, BAD_PIN_O, BAD_OE_O;
  logic [1:0] FSYNC_PIN_I, FSYNC_EDGE_O;
  logic [7:0] rst_val [3] = '{8'hDF, 8'h1F, 8'h3F};
  int         n_errors = 0;
  int         n_checks = 0;

  alarm_polarity_and_irq_mask u_alarm_polarity_and_irq_mask (.*);
  host_pin_watch u_host_pin_watch (.pin_i(IRQ_PIN_O), .oe_i(IRQ_OE_O),
                                   .wire_o(irq_wire));

  always #10 CLK_I = ~CLK_I;

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge CLK_I);
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    REG_WR_I = 1'b1;
    @(negedge CLK_I);
    REG_WR_I = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(negedge CLK_I);
    REG_ADDR_I = a;
    REG_RD_I = 1'b1;
    @(negedge CLK_I);
    REG_RD_I = 1'b0;
    chk("read data", REG_RDATA_O, exp);
  endtask

  // mask bit k pairs with flag bit k
  task automatic wr_masks(input logic [10:0] m);
    wr(8'h17, {3'h0, m[4:0]});
    wr(8'h18, {2'h0, m[10:5]});
    @(negedge CLK_I);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    CLK_I = 1'b0;
    RST_N_I = 1'b0;
    {ALIGN_FLAG_I, FOS_FLAG_I, LOL_FLAG_I, LOSS_FLAG_I, XTAL_LOSS_I} = '0;
    {ACTV_STAT_I, ACTV_EN_I, BAD_STAT_I, BAD_EN_I} = 14'h3FFF;
    {LOL_STAT_I, LOL_EN_I, FSYNC_STAT_I, IRQ_REFL_EN_I, ALRM_REFL_EN_I} = '1;
    {ALRM_STAT_I, REALIGN_PIN_I, FSYNC_PIN_I, REG_WR_I, REG_RD_I} = '0;
    {REG_ADDR_I, REG_WDATA_I} = 16'h0000;
    repeat (3) @(negedge CLK_I);
    RST_N_I = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(8'h16 + 8'(i), rst_val[i]);
      wr(8'h16 + 8'(i), 8'hFF);
      rd(8'h16 + 8'(i), rst_val[i]);
      wr(8'h16 + 8'(i), 8'h00);
      rd(8'h16 + 8'(i), 8'h00);
    end
    wr(8'h19, 8'hFF);
    rd(8'h19, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 11; k++) begin
      // from the second pass on, the previous pass left this flag masked
      wr_masks(11'h000);
      {ALIGN_FLAG_I, FOS_FLAG_I, LOL_FLAG_I, LOSS_FLAG_I, XTAL_LOSS_I} =
        11'h001 << k;
      @(negedge CLK_I);
      chk("irq status", IRQ_STATUS_O, 8'h01);
      chk("irq pin low", IRQ_PIN_O, 8'h00);
      wr_masks(11'h001 << k);
      chk("irq masked", IRQ_STATUS_O, 8'h00);
      wr_masks(~(11'h001 << k));
      chk("flag kept", IRQ_STATUS_O, 8'h01);
    end
    wr_masks(11'h000);
    XTAL_LOSS_I = 1'b1;
    $display("test masking done");
    for (int i = 0; i < 2; i++) begin
      p = i[0];
      ACTV_EN_I = {4{p}};
      BAD_EN_I = {3{p}};
      wr(8'h16, p ? 8'h1F : 8'h00);
      @(negedge CLK_I);
      chk("active pins", ACTV_PIN_O, {4{p}});
      chk("active enables", ACTV_OE_O, {4{p}});
      chk("bad pins", BAD_PIN_O, {3{p}});
      chk("bad enables", BAD_OE_O, {3{p}});
      chk("lock loss pin", LOL_PIN_O, p);
      chk("sync out pin", FSYNC_OUT_O, p);
      chk("irq over alarm", irq_wire, p);
      IRQ_REFL_EN_I = 1'b0;
      ALRM_STAT_I = 1'b1;
      @(negedge CLK_I);
      chk("alarm pin", irq_wire, p);
      ALRM_REFL_EN_I = 1'b0;
      ALRM_STAT_I = 1'b0;
      @(negedge CLK_I);
      chk("pin released", IRQ_OE_O, 8'h00);
      chk("board level", irq_wire, 8'h01);
      {IRQ_REFL_EN_I, ALRM_REFL_EN_I} = 2'h3;
    end
    $display("test polarity done");
    for (int i = 0; i < 2; i++) begin
      p = i[0];
      wr(8'h16, p ? 8'h80 : 8'h40);
      REALIGN_PIN_I = ~p;
      FSYNC_PIN_I = {2{p}};
      repeat (2) @(negedge CLK_I);
      REALIGN_PIN_I = p;
      FSYNC_PIN_I = {2{~p}};
      @(negedge CLK_I);
      chk("realign pulse", REALIGN_O, 8'h01);
      chk("realign level", REALIGN_LVL_O, 8'h01);
      chk("sync edges", FSYNC_EDGE_O, 8'h03);
      @(negedge CLK_I);
      chk("realign once", REALIGN_O, 8'h00);
      chk("sync once", FSYNC_EDGE_O, 8'h00);
      REALIGN_PIN_I = ~p;
      FSYNC_PIN_I = {2{p}};
      @(negedge CLK_I);
      chk("realign idle edge", REALIGN_O, 8'h00);
      chk("sync idle edge", FSYNC_EDGE_O, 8'h00);
    end
    $display("test edges done");
    report_and_stop;
  end

  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
endmodule
